// ---- core/bsps_pin_mux.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "bsps_params.svh"

module bsps_pin_mux (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // programmable flag pins, 0..3 double as straps, 4..7 as interrupts
  input wire logic [7:0] prog_flag_in,
  output logic [7:0] prog_flag_out,
  output logic [7:0] prog_flag_oe,
  // second serial port pins: [0] irq0, [1] irq1, [2] flag in
  input wire logic [2:0] second_serial_port_in,
  output logic second_serial_port_tx,
  input wire logic serial_tx_data,
  output logic [2:0] serial_rx_pins,
  // core memory request
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic mem_byte,
  input wire logic [21:0] mem_addr,
  input wire logic [23:0] mem_wdata,
  output logic [23:0] mem_rdata,
  // external memory pins
  output logic [13:0] external_address_bus,
  input wire logic [23:0] external_data_bus_in,
  output logic [23:0] external_data_bus_out,
  output logic [23:0] external_data_bus_oe,
  // mode and interrupt request to the sequencer
  output logic host_mode,
  output logic irq_req,
  output logic [2:0] irq_sel
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic pin_asserted(input logic drive, input logic out_val, input logic pin_val);
    // active low; a pin we drive is seen at its driven level
    pin_asserted = drive ? ~out_val : ~pin_val;
  endfunction

  function automatic logic [3:0] pick_first(input bsps_pkg::bsps_irq_vec_t v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 5; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    pick_first = r;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [7:0] pf_s1, pf_s2;
  logic [2:0] sp_s1, sp_s2;
  logic [23:0] db_s1, db_s2;

  // data path only: no reset so straps are seen while rst is high
  always_ff @(posedge clk) begin
    pf_s1 <= prog_flag_in;
    pf_s2 <= pf_s1;
    sp_s1 <= second_serial_port_in;
    sp_s2 <= sp_s1;
    db_s1 <= external_data_bus_in;
    db_s2 <= db_s1;
  end

  // ----------------------------------------
  // strap capture and phase
  // ----------------------------------------
  logic [3:0] mode_reg;
  logic host_reg;
  bsps_pkg::bsps_phase_t phase_reg, phase_next;

  always_comb begin
    case (phase_reg)
      bsps_pkg::BSPS_PH_STRAP: phase_next = bsps_pkg::BSPS_PH_RUN;
      bsps_pkg::BSPS_PH_RUN: phase_next = bsps_pkg::BSPS_PH_RUN;
      default: phase_next = bsps_pkg::BSPS_PH_STRAP;
    endcase
  end

  // straps sampled every reset cycle, frozen after release
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= pf_s2[3:0];
      host_reg <= pf_s2[`BSPS_MODE_C_BIT];
      phase_reg <= bsps_pkg::BSPS_PH_STRAP;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] flag_dir_reg;
  logic [7:0] flag_out_reg;
  logic [5:0] irq_mask_reg;
  logic [4:0] sys_ctrl_reg;
  logic [15:0] rdata_reg;
  logic wr_dir, wr_out, wr_mask, wr_ctrl, wr_pend;

  assign wr_dir = reg_wr && (reg_addr == `BSPS_OFF_FLAG_DIR);
  assign wr_out = reg_wr && (reg_addr == `BSPS_OFF_FLAG_OUT);
  assign wr_mask = reg_wr && (reg_addr == `BSPS_OFF_IRQ_MASK);
  assign wr_ctrl = reg_wr && (reg_addr == `BSPS_OFF_SYS_CTRL);
  assign wr_pend = reg_wr && (reg_addr == `BSPS_OFF_IRQ_PEND);

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_dir_reg <= `BSPS_RST_FLAG_DIR;
      flag_out_reg <= `BSPS_RST_FLAG_OUT;
      irq_mask_reg <= `BSPS_RST_IRQ_MASK;
      sys_ctrl_reg <= `BSPS_RST_SYS_CTRL;
    end else begin
      if (wr_dir) begin
        flag_dir_reg <= reg_wdata[7:0];
      end
      if (wr_out) begin
        flag_out_reg <= reg_wdata[7:0];
      end
      if (wr_mask) begin
        irq_mask_reg <= reg_wdata[5:0];
      end
      if (wr_ctrl) begin
        sys_ctrl_reg <= reg_wdata[4:0];
      end
    end
  end

  // ----------------------------------------
  // interrupt sensing
  // ----------------------------------------
  bsps_irq_if irq_bus ();
  logic alt_en;
  logic [3:0] pick;

  assign alt_en = sys_ctrl_reg[`BSPS_CTL_ALT_EN];

  // shared pins feed interrupts whatever their flag direction
  assign irq_bus.asserted[`BSPS_IRQ_CFG] = pin_asserted(flag_dir_reg[7], flag_out_reg[7], pf_s2[7]);
  assign irq_bus.asserted[`BSPS_IRQ_LVL_HIGH] = pin_asserted(flag_dir_reg[6], flag_out_reg[6], pf_s2[6]);
  assign irq_bus.asserted[`BSPS_IRQ_LVL_LOW] = pin_asserted(flag_dir_reg[5], flag_out_reg[5], pf_s2[5]);
  assign irq_bus.asserted[`BSPS_IRQ_EDGE] = pin_asserted(flag_dir_reg[4], flag_out_reg[4], pf_s2[4]);
  assign irq_bus.asserted[`BSPS_IRQ_SER1] = alt_en & ~sp_s2[1];
  assign irq_bus.asserted[`BSPS_IRQ_SER0] = alt_en & ~sp_s2[0];

  assign irq_bus.edge_mode[`BSPS_IRQ_CFG] = sys_ctrl_reg[`BSPS_CTL_CFG_EDGE];
  assign irq_bus.edge_mode[`BSPS_IRQ_LVL_HIGH] = 1'b0;
  assign irq_bus.edge_mode[`BSPS_IRQ_LVL_LOW] = 1'b0;
  assign irq_bus.edge_mode[`BSPS_IRQ_EDGE] = 1'b1;
  assign irq_bus.edge_mode[`BSPS_IRQ_SER1] = sys_ctrl_reg[`BSPS_CTL_SER1_EDGE];
  assign irq_bus.edge_mode[`BSPS_IRQ_SER0] = sys_ctrl_reg[`BSPS_CTL_SER0_EDGE];

  assign irq_bus.clear = wr_pend ? reg_wdata[5:0] : 6'h00;

  bsps_irq_sense u_sense (
    .clk(clk),
    .rst(rst),
    .irq(irq_bus.sense)
  );

  assign pick = pick_first(irq_bus.pend & irq_mask_reg);

  logic irq_req_reg;
  logic [2:0] irq_sel_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_req_reg <= 1'b0;
      irq_sel_reg <= 3'h0;
    end else begin
      irq_req_reg <= pick[3];
      irq_sel_reg <= pick[2:0];
    end
  end

  // ----------------------------------------
  // second serial port steering
  // ----------------------------------------
  logic sp_tx_reg;
  logic [2:0] sp_rx_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      sp_tx_reg <= 1'b1;
      sp_rx_reg <= 3'h7;
    end else begin
      sp_tx_reg <= alt_en ? sys_ctrl_reg[`BSPS_CTL_ALT_FOUT] : serial_tx_data;
      sp_rx_reg <= alt_en ? 3'h7 : sp_s2;
    end
  end

  // ----------------------------------------
  // external memory pins
  // ----------------------------------------
  logic [13:0] addr_reg, addr_next;
  logic [23:0] dout_reg, dout_next;
  logic [23:0] doe_reg, doe_next;
  logic [23:0] raw_oe;

  // byte accesses carry address bits 21:14 on the top data byte
  assign raw_oe = mem_byte ? {8'hff, 8'h00, {8{mem_write}}} : {24{mem_write}};
  assign addr_next = mem_req ? (mem_addr[13:0] & (host_reg ? `BSPS_HOST_ADDR_MASK : 14'h3fff)) : addr_reg;
  assign dout_next = mem_byte ? {mem_addr[21:14], 8'h00, mem_wdata[7:0]} : mem_wdata;
  // low data byte belongs to the host port in host mode
  assign doe_next = mem_req ? (raw_oe & (host_reg ? `BSPS_HOST_DATA_MASK : 24'hffffff)) : 24'h000000;

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_reg <= 14'h0000;
      dout_reg <= 24'h000000;
      doe_reg <= 24'h000000;
    end else begin
      addr_reg <= addr_next;
      dout_reg <= mem_req ? dout_next : dout_reg;
      doe_reg <= doe_next;
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  logic [15:0] rmux;

  always_comb begin
    case (reg_addr)
      `BSPS_OFF_FLAG_DIR: rmux = {8'h00, flag_dir_reg};
      `BSPS_OFF_FLAG_OUT: rmux = {8'h00, flag_out_reg};
      `BSPS_OFF_IRQ_MASK: rmux = {10'h000, irq_mask_reg};
      `BSPS_OFF_SYS_CTRL: rmux = {11'h000, sys_ctrl_reg};
      `BSPS_OFF_STATUS: rmux = {10'h000, phase_reg == bsps_pkg::BSPS_PH_RUN, host_reg, mode_reg};
      `BSPS_OFF_FLAG_IN: rmux = {7'h00, alt_en & sp_s2[2], pf_s2};
      `BSPS_OFF_IRQ_PEND: rmux = {10'h000, irq_bus.pend};
      default: rmux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= reg_rd ? rmux : 16'h0000;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = rdata_reg;
  assign prog_flag_out = flag_out_reg;
  assign prog_flag_oe = flag_dir_reg;
  assign second_serial_port_tx = sp_tx_reg;
  assign serial_rx_pins = sp_rx_reg;
  assign mem_rdata = db_s2;
  assign external_address_bus = addr_reg;
  assign external_data_bus_out = dout_reg;
  assign external_data_bus_oe = doe_reg;
  assign host_mode = host_reg;
  assign irq_req = irq_req_reg;
  assign irq_sel = irq_sel_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence dir_write_s;
    reg_wr && (reg_addr == `BSPS_OFF_FLAG_DIR);
  endsequence

  sequence cfg_driven_low_s;
    flag_dir_reg[7] && !flag_out_reg[7] && irq_mask_reg[`BSPS_IRQ_CFG] && !sys_ctrl_reg[`BSPS_CTL_CFG_EDGE];
  endsequence

  mode_hold_a: assert property (!$past(rst) |-> ($stable(mode_reg) && $stable(host_reg)))
    else $error("mode changed while running");
  host_sel_a: assert property (host_mode == mode_reg[`BSPS_MODE_C_BIT])
    else $error("host mode not from mode strap");
  flag_dflt_a: assert property ($past(rst) |-> (prog_flag_oe == 8'h00))
    else $error("flag pins driven after reset");
  dir_write_a: assert property (dir_write_s |=> (prog_flag_oe == $past(reg_wdata[7:0])))
    else $error("flag direction not written");
  shared_irq_a: assert property (cfg_driven_low_s [*2] |-> ##1 (irq_req && irq_sel == 3'h0))
    else $error("flag-driven interrupt not requested");
  edge_sense_a: assert property (irq_bus.edge_mode[`BSPS_IRQ_EDGE] && !irq_bus.edge_mode[`BSPS_IRQ_LVL_HIGH])
    else $error("fixed sense changed");
  serial_alt_a: assert property (alt_en |=> (second_serial_port_tx == $past(sys_ctrl_reg[`BSPS_CTL_ALT_FOUT])))
    else $error("flag out not on serial pin");
  full_addr_a: assert property ((mem_req && !host_reg) |=> (external_address_bus == $past(mem_addr[13:0])))
    else $error("address not driven");
  byte_addr_a: assert property ((mem_req && mem_byte && !host_reg) |=>
    (external_data_bus_out[23:16] == $past(mem_addr[21:14]) && external_data_bus_oe[23:16] == 8'hff))
    else $error("byte address not on data lines");
  read_one_a: assert property (!reg_rd |=> (reg_rdata == 16'h0000))
    else $error("read data outside answer cycle");

endmodule

`default_nettype wire

// ---- common/bsps_params.svh ----
`ifndef BSPS_PARAMS_SVH
`define BSPS_PARAMS_SVH

// ----------------------------------------
// register offsets (4-bit word index)
// ----------------------------------------
`define BSPS_OFF_FLAG_DIR 4'h0
`define BSPS_OFF_FLAG_OUT 4'h1
`define BSPS_OFF_IRQ_MASK 4'h2
`define BSPS_OFF_SYS_CTRL 4'h3
`define BSPS_OFF_STATUS 4'h4
`define BSPS_OFF_FLAG_IN 4'h5
`define BSPS_OFF_IRQ_PEND 4'h6

// ----------------------------------------
// system control fields
// ----------------------------------------
`define BSPS_CTL_ALT_EN 0
`define BSPS_CTL_CFG_EDGE 1
`define BSPS_CTL_SER1_EDGE 2
`define BSPS_CTL_SER0_EDGE 3
`define BSPS_CTL_ALT_FOUT 4

// ----------------------------------------
// status and flag input fields
// ----------------------------------------
`define BSPS_STS_MODE_LSB 0
`define BSPS_STS_HOST 4
`define BSPS_STS_RUN 5
`define BSPS_FIN_ALT 8

// ----------------------------------------
// interrupt index, highest priority first
// ----------------------------------------
`define BSPS_IRQ_CFG 0
`define BSPS_IRQ_LVL_HIGH 1
`define BSPS_IRQ_LVL_LOW 2
`define BSPS_IRQ_EDGE 3
`define BSPS_IRQ_SER1 4
`define BSPS_IRQ_SER0 5

// ----------------------------------------
// strap layout and reset values
// ----------------------------------------
`define BSPS_MODE_C_BIT 2
`define BSPS_HOST_ADDR_MASK 14'h0001
`define BSPS_HOST_DATA_MASK 24'hffff00
`define BSPS_RST_FLAG_DIR 8'h00
`define BSPS_RST_FLAG_OUT 8'hff
`define BSPS_RST_IRQ_MASK 6'h00
`define BSPS_RST_SYS_CTRL 5'h10

`endif

// ---- common/bsps_pkg.sv ----
package bsps_pkg;

  typedef enum logic [1:0] {
    BSPS_PH_STRAP = 2'b00,
    BSPS_PH_RUN = 2'b01
  } bsps_phase_t;

  typedef logic [5:0] bsps_irq_vec_t;

endpackage

// ---- common/bsps_irq_if.sv ----
`timescale 1ns/100ps
`default_nettype none

interface bsps_irq_if;
  bsps_pkg::bsps_irq_vec_t asserted;
  bsps_pkg::bsps_irq_vec_t edge_mode;
  bsps_pkg::bsps_irq_vec_t clear;
  bsps_pkg::bsps_irq_vec_t pend;

  modport ctrl (output asserted, output edge_mode, output clear, input pend);
  modport sense (input asserted, input edge_mode, input clear, output pend);
endinterface

`default_nettype wire

// ---- core/bsps_irq_sense.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "bsps_params.svh"

module bsps_irq_sense (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request lines
  bsps_irq_if.sense irq
);

  bsps_pkg::bsps_irq_vec_t prev_reg;
  bsps_pkg::bsps_irq_vec_t latch_reg;
  bsps_pkg::bsps_irq_vec_t latch_next;
  bsps_pkg::bsps_irq_vec_t rise;

  assign rise = irq.asserted & ~prev_reg;
  // set beats a clear landing in the same cycle
  assign latch_next = (rise & irq.edge_mode) | (latch_reg & ~irq.clear & irq.edge_mode);
  assign irq.pend = (latch_reg & irq.edge_mode) | (irq.asserted & ~irq.edge_mode);

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= 6'h00;
      latch_reg <= 6'h00;
    end else begin
      prev_reg <= irq.asserted;
      latch_reg <= latch_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  set_wins_a: assert property (((rise & irq.edge_mode) != 6'h00) |=>
    ((irq.pend & $past(rise & irq.edge_mode)) == $past(rise & irq.edge_mode)))
    else $error("edge lost against clear");
  level_follow_a: assert property (irq.pend[`BSPS_IRQ_LVL_LOW] == irq.asserted[`BSPS_IRQ_LVL_LOW])
    else $error("level input not followed");

endmodule

`default_nettype wire

// ---- dv/bsps_board_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module bsps_board_model (
  // device side of the shared pins
  input wire logic [7:0] flag_out,
  input wire logic [7:0] flag_oe,
  input wire logic [13:0] addr,
  input wire logic [23:0] dat_out,
  input wire logic [23:0] dat_oe,
  // board conditions set by the bench
  input wire logic [3:0] strap,
  input wire logic [3:0] irq_n,
  // resolved pin levels
  output logic [7:0] flag_pin,
  output logic [23:0] dat_pin
);
  // ----------------------------------------
  // straps and pulled-up request lines
  // ----------------------------------------
  // strap resistors stay on the board, so an undriven flag pin 0..3 reads its strap
  wire logic [7:0] board_lvl = {irq_n, strap};
  assign flag_pin = (flag_oe & flag_out) | (~flag_oe & board_lvl);
  // ----------------------------------------
  // external memory
  // ----------------------------------------
  // memory answers every address; the device wins wherever it drives
  assign dat_pin = (dat_oe & dat_out) | (~dat_oe & {10'h2a5, addr});
endmodule

`default_nettype wire

// ---- dv/boot_strap_pin_sharing_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "bsps_params.svh"

module boot_strap_pin_sharing_test;
  // ----------------------------------------
  // stimulus, pins and reference state
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, stat;
  logic [7:0] flag_in, flag_out, flag_oe, v;
  logic [2:0] ser_in = 3'h7;
  logic [2:0] rx_pins, irq_sel;
  logic tx_data = 1'b1;
  logic ser_tx, host, irq_req;
  logic mem_req = 1'b0;
  logic mem_write = 1'b0;
  logic mem_byte = 1'b0;
  logic [21:0] mem_addr = 22'h000000;
  logic [23:0] mem_wdata = 24'h000000;
  logic [23:0] mem_rdata, bus_in, bus_out, bus_oe;
  logic [13:0] addr_pins;
  logic [3:0] strap = 4'h0;
  logic [3:0] irq_n = 4'hf;
  int seed = 32'hc6ae;
  int n_fail = 0;
  int num_checks = 0;
  int m_dir, m_out, m_mask, m_ctrl, m_host;

  always #12.5 clk = ~clk;

  bsps_pin_mux i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prog_flag_in(flag_in), .prog_flag_out(flag_out),
    .prog_flag_oe(flag_oe), .second_serial_port_in(ser_in), .second_serial_port_tx(ser_tx),
    .serial_tx_data(tx_data), .serial_rx_pins(rx_pins), .mem_req(mem_req), .mem_write(mem_write),
    .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .external_address_bus(addr_pins), .external_data_bus_in(bus_in), .external_data_bus_out(bus_out),
    .external_data_bus_oe(bus_oe), .host_mode(host), .irq_req(irq_req), .irq_sel(irq_sel));

  bsps_board_model i_board (.flag_out(flag_out), .flag_oe(flag_oe), .addr(addr_pins), .dat_out(bus_out),
    .dat_oe(bus_oe), .strap(strap), .irq_n(irq_n), .flag_pin(flag_in), .dat_pin(bus_in));

  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check_val(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    case (a)
      `BSPS_OFF_FLAG_DIR: m_dir = d[7:0];
      `BSPS_OFF_FLAG_OUT: m_out = d[7:0];
      `BSPS_OFF_IRQ_MASK: m_mask = d[5:0];
      `BSPS_OFF_SYS_CTRL: m_ctrl = d[4:0];
      default: ;
    endcase
  endtask

  task automatic reg_check(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check_val({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // act holds the active request lines by priority index; the lowest index enabled in the mask wins
  task automatic check_irq(input int act);
    int p;
    p = 7;
    for (int i = 5; i >= 0; i--) begin
      if (act[i] && m_mask[i]) begin
        p = i;
      end
    end
    repeat (6) @(negedge clk);
    if (p == 7) begin
      check_val({23'h0, irq_req}, 24'h000000);
    end else begin
      check_val({20'h0, irq_req, irq_sel}, {20'h0, 1'b1, 3'(p)});
    end
  endtask

  task automatic pulse(input logic [3:0] n);
    @(posedge clk);
    irq_n <= n;
    repeat (3) @(posedge clk);
    irq_n <= 4'hf;
  endtask

  task automatic reset_dut(input logic [3:0] s);
    rst <= 1'b1;
    strap <= s;
    m_dir = 8'h00;
    m_out = 8'hff;
    m_mask = 0;
    m_ctrl = 8'h10;
    m_host = s[2];
    stat = {10'h000, 1'b1, s[2], s};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check_val({8'h00, flag_oe, flag_out}, 24'h0000ff);
    check_val({23'h0, host}, {23'h0, s[2]});
    reg_check(`BSPS_OFF_FLAG_DIR, 16'(m_dir));
    reg_check(`BSPS_OFF_FLAG_OUT, 16'(m_out));
    reg_check(`BSPS_OFF_IRQ_MASK, 16'(m_mask));
    reg_check(`BSPS_OFF_SYS_CTRL, 16'(m_ctrl));
    reg_check(`BSPS_OFF_STATUS, stat);
  endtask

  task automatic mem_op(input logic wr, input logic byt);
    logic [21:0] a;
    logic [23:0] w, eo, ed;
    logic [13:0] ea;
    a = 22'($random(seed));
    w = 24'($random(seed));
    ea = m_host ? {13'h0000, a[0]} : a[13:0];
    eo = byt ? (wr ? 24'hff00ff : 24'hff0000) : (wr ? 24'hffffff : 24'h000000);
    if (m_host) begin
      eo[7:0] = 8'h00;
    end
    ed = byt ? {a[21:14], 8'h00, w[7:0]} : w;
    @(posedge clk);
    mem_req <= 1'b1;
    mem_write <= wr;
    mem_byte <= byt;
    mem_addr <= a;
    mem_wdata <= w;
    @(posedge clk);
    mem_req <= 1'b0;
    @(negedge clk);
    check_val({10'h000, addr_pins}, {10'h000, ea});
    check_val(bus_oe, eo);
    check_val(bus_out & eo, ed & eo);
    @(negedge clk);
    check_val(bus_oe, 24'h000000);
    repeat (2) @(negedge clk);
    check_val(mem_rdata, {10'h2a5, ea});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_dut(4'($random(seed)) & 4'hb);
    @(posedge clk);
    strap <= ~strap;
    repeat (4) @(negedge clk);
    check_val({23'h0, host}, {23'h0, m_host[0]});
    reg_check(`BSPS_OFF_FLAG_IN, {8'h00, irq_n, strap});
    reg_write(`BSPS_OFF_STATUS, 16'hffff);
    reg_check(`BSPS_OFF_STATUS, stat);
    reg_check(4'h9, 16'h0000);
    v = 8'($random(seed));
    reg_write(`BSPS_OFF_FLAG_DIR, 16'h000f);
    reg_write(`BSPS_OFF_FLAG_OUT, {8'h00, v});
    repeat (3) @(negedge clk);
    check_val({8'h00, flag_oe, flag_out}, {16'h000f, v});
    reg_check(`BSPS_OFF_FLAG_IN, {8'h00, irq_n, v[3:0]});
    reg_write(`BSPS_OFF_IRQ_MASK, 16'h0001);
    @(posedge clk);
    irq_n <= 4'h7;
    check_irq(1);
    reg_check(`BSPS_OFF_FLAG_IN, {8'h00, 4'h7, v[3:0]});
    reg_write(`BSPS_OFF_IRQ_MASK, 16'h0000);
    check_irq(1);
    @(posedge clk);
    irq_n <= 4'hf;
    reg_write(`BSPS_OFF_IRQ_MASK, 16'h0001);
    reg_write(`BSPS_OFF_FLAG_DIR, 16'h008f);
    reg_write(`BSPS_OFF_FLAG_OUT, {8'h00, 4'h7, v[3:0]});
    check_irq(1);
    reg_write(`BSPS_OFF_FLAG_DIR, 16'h000f);
    check_irq(0);
    reg_write(`BSPS_OFF_IRQ_MASK, 16'h003f);
    pulse(4'he);
    check_irq(8);
    @(posedge clk);
    irq_n <= 4'hd;
    check_irq(12);
    @(posedge clk);
    irq_n <= 4'hf;
    check_irq(8);
    reg_write(`BSPS_OFF_IRQ_PEND, 16'h0008);
    check_irq(0);
    reg_write(`BSPS_OFF_SYS_CTRL, 16'h0012);
    pulse(4'h7);
    check_irq(1);
    reg_write(`BSPS_OFF_IRQ_PEND, 16'h0001);
    check_irq(0);
    reg_write(`BSPS_OFF_SYS_CTRL, 16'h0010);
    pulse(4'h7);
    check_irq(0);
    @(posedge clk);
    ser_in <= 3'($random(seed));
    tx_data <= 1'b0;
    @(posedge clk);
    tx_data <= 1'b1;
    @(negedge clk);
    check_val({23'h0, ser_tx}, 24'h000000);
    repeat (3) @(negedge clk);
    check_val({21'h0, rx_pins}, {21'h0, ser_in});
    check_irq(0);
    reg_write(`BSPS_OFF_SYS_CTRL, 16'h0001);
    reg_check(`BSPS_OFF_SYS_CTRL, 16'(m_ctrl));
    @(posedge clk);
    ser_in <= 3'h6;
    repeat (3) @(negedge clk);
    check_val({20'h0, ser_tx, rx_pins}, 24'h000007);
    reg_check(`BSPS_OFF_FLAG_IN, {7'h00, 1'b1, 4'hf, v[3:0]});
    check_irq(32);
    @(posedge clk);
    ser_in <= 3'h1;
    check_irq(16);
    reg_check(`BSPS_OFF_FLAG_IN, {8'h00, 4'hf, v[3:0]});
    reg_write(`BSPS_OFF_SYS_CTRL, 16'h0011);
    repeat (3) @(negedge clk);
    check_val({23'h0, ser_tx}, 24'h000001);
    @(posedge clk);
    ser_in <= 3'h7;
    reg_write(`BSPS_OFF_SYS_CTRL, 16'h001d);
    @(posedge clk);
    ser_in <= 3'h4;
    repeat (3) @(posedge clk);
    ser_in <= 3'h7;
    check_irq(48);
    reg_check(`BSPS_OFF_IRQ_PEND, 16'h0030);
    reg_write(`BSPS_OFF_IRQ_PEND, 16'h0010);
    check_irq(32);
    reg_write(`BSPS_OFF_IRQ_PEND, 16'h0020);
    check_irq(0);
    for (int i = 0; i < 8; i++) begin
      mem_op(i[0], i[1]);
    end
    reset_dut(4'h4);
    @(posedge clk);
    strap <= 4'h0;
    repeat (4) @(negedge clk);
    check_val({23'h0, host}, 24'h000001);
    for (int i = 0; i < 4; i++) begin
      mem_op(i[0], i[1]);
    end
    give_verdict();
  end
endmodule

`default_nettype wire
